// ---- ssc_map.svh ----
// constants for the setpoint sequence controller: limits, reset values, timing
// assumes a 50 MHz system clock; included by the package and the controller
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
`define SSC_ADDR_MIN 8'h0b
`define SSC_ADDR_MAX 8'hff
`define SSC_NLOC 245
`define SSC_VW 16
`define SSC_CW 16
`define SSC_TW 14
`define SSC_START_RST 8'h0b
`define SSC_STOP_RST 8'hff
`define SSC_REP_ENDLESS 10'h3e7
`define SSC_STAT_LEN 8'h15
`define SSC_BOUNDS_LEN 8'h12
`define SSC_EXE_BIT 4
`define SSC_TICK_MS 10
`define SSC_CLK_KHZ 50000
`define SSC_TICK_CYC (`SSC_TICK_MS * `SSC_CLK_KHZ)
`endif

// ---- ssc_pkg.sv ----
// types shared by the setpoint sequence controller and its environment
// assumes ssc_map.svh is on the include path
`include "ssc_map.svh"
package ssc_pkg;
	typedef enum logic [2:0] {
		SSC_CMD_WRITE, SSC_CMD_BOUNDS, SSC_CMD_RUN, SSC_CMD_PAUSE,
		SSC_CMD_RESUME, SSC_CMD_STEP_BEGIN, SSC_CMD_STEP, SSC_CMD_STOP
	} ssc_cmd_code_t;
	typedef enum logic [1:0] {
		SSC_OPT_NONE, SSC_OPT_ON, SSC_OPT_OFF, SSC_OPT_CLEAR
	} ssc_opt_t;
	typedef enum logic [1:0] {SSC_ST_READY, SSC_ST_RUN, SSC_ST_HOLD} ssc_report_t;
	typedef struct packed {
		logic valid;
		logic [`SSC_VW-1:0] volt;
		logic [`SSC_CW-1:0] curr;
		logic [`SSC_TW-1:0] dwell;
	} ssc_loc_t;
	typedef struct packed {
		ssc_cmd_code_t code;
		ssc_opt_t opt;
		logic [7:0] addr_a;
		logic [7:0] addr_b;
		logic [`SSC_VW-1:0] volt;
		logic [`SSC_CW-1:0] curr;
		logic [`SSC_TW-1:0] dwell;
	} ssc_cmd_t;
	typedef struct packed {
		logic [7:0] length;
		ssc_report_t state;
		logic [9:0] repeats;
		logic [7:0] addr;
	} ssc_status_t;
	typedef struct packed {
		logic [7:0] length;
		logic [7:0] start;
		logic [7:0] stop;
	} ssc_bounds_t;
endpackage

// ---- ssc_seq.sv ----
// setpoint sequence controller: location memory, bounds, run/step sequencing
// assumes commands come from decode logic on the same clock, one per accepted cycle
`timescale 1ns/1ps
`include "ssc_map.svh"

module ssc_seq import ssc_pkg::*; #(
	parameter int TICK_CYC = `SSC_TICK_CYC // cycles per 10 ms dwell unit
) (
	input wire logic clk_i, // 50 MHz system clock
	input wire logic nrst_i, // async reset, active low
	input wire logic cmd_valid_i, // command offered
	output logic cmd_ready_o, // command taken when valid and ready
	input wire ssc_cmd_t cmd_i, // command and its operands
	input wire logic dev_reset_i, // device reset pulse
	input wire logic seq_init_i, // sequence function initialized
	input wire logic [7:0] repetition_i, // 0 endless, else pass count
	input wire logic [`SSC_TW-1:0] default_dwell_i, // default dwell, 10 ms units
	input wire logic esr_clear_i, // clears the standard event register
	output logic [`SSC_VW-1:0] volt_set_o, // applied voltage setpoint
	output logic [`SSC_CW-1:0] curr_set_o, // applied current setpoint
	output logic output_on_o, // power output switched on
	output ssc_status_t status_o, // sequence status reply
	output ssc_bounds_t bounds_o, // bounds reply
	output logic [7:0] std_event_o // standard event register
);
	typedef enum logic [2:0] {S_IDLE, S_SEEK, S_DWELL, S_HOLD, S_STEPW} ssc_fsm_t;
	localparam int TW = $clog2(TICK_CYC);

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic in_range(input logic [7:0] a);
		in_range = (a >= `SSC_ADDR_MIN);
	endfunction
	function automatic logic [7:0] idx(input logic [8:0] a);
		idx = 8'(a - 9'(`SSC_ADDR_MIN));
	endfunction

	ssc_loc_t mem_reg [`SSC_NLOC];
	ssc_loc_t mem_next [`SSC_NLOC];
	ssc_fsm_t state_reg, state_next;
	logic step_mode_reg, step_mode_next;
	logic found_reg, found_next;
	logic [8:0] ptr_reg, ptr_next;
	logic [7:0] rep_reg, rep_next;
	logic endless_reg, endless_next;
	logic [7:0] start_reg, start_next, stop_reg, stop_next;
	logic [7:0] cur_reg, cur_next;
	logic [`SSC_TW-1:0] dwell_reg, dwell_next;
	logic [TW-1:0] tick_reg, tick_next;
	logic [`SSC_VW-1:0] volt_reg, volt_next;
	logic [`SSC_CW-1:0] curr_reg, curr_next;
	logic on_reg, on_next;
	logic [7:0] esr_reg, esr_next;
	logic take;
	ssc_loc_t loc;

	// past the top address the index leaves the memory; loc is only read while ptr is in range
	assign cmd_ready_o = (state_reg != S_SEEK); // scan finishes before the next command
	assign take = cmd_valid_i && cmd_ready_o;
	assign loc = mem_reg[idx(ptr_reg)];

	// --------------------------------------------------------------
	// next state: commands, scan, dwell timing
	// --------------------------------------------------------------
	always_comb begin
		ssc_loc_t stop_loc;
		logic execution_error_flag;
		stop_loc = mem_reg[idx({1'b0, stop_reg})];
		execution_error_flag = 1'b0;
		mem_next = mem_reg;
		state_next = state_reg;
		step_mode_next = step_mode_reg;
		found_next = found_reg;
		ptr_next = ptr_reg;
		rep_next = rep_reg;
		endless_next = endless_reg;
		start_next = start_reg;
		stop_next = stop_reg;
		cur_next = cur_reg;
		dwell_next = dwell_reg;
		tick_next = tick_reg;
		volt_next = volt_reg;
		curr_next = curr_reg;
		on_next = on_reg;
		case (state_reg)
			S_SEEK: begin
				// one address per cycle: empty locations cost a cycle each, traded for no priority encoder
				if (ptr_reg > {1'b0, stop_reg}) begin
					if (!found_reg) begin
						state_next = S_IDLE; // nothing executable in range
					end else if (step_mode_reg) begin
						ptr_next = {1'b0, start_reg};
						found_next = 1'b0;
					end else if (endless_reg || rep_reg > 8'h01) begin
						rep_next = endless_reg ? rep_reg : 8'(rep_reg - 8'h01);
						ptr_next = {1'b0, start_reg};
						found_next = 1'b0;
					end else begin
						rep_next = 8'h00;
						state_next = S_IDLE;
					end
				end else if (loc.valid) begin
					volt_next = loc.volt;
					curr_next = loc.curr;
					cur_next = ptr_reg[7:0];
					found_next = 1'b1;
					ptr_next = ptr_reg + 9'h001;
					dwell_next = (loc.dwell == '0) ? default_dwell_i : loc.dwell;
					tick_next = '0;
					state_next = step_mode_reg ? S_STEPW : S_DWELL;
				end else begin
					ptr_next = ptr_reg + 9'h001;
				end
			end
			S_DWELL: begin
				// dwell counted in 10 ms units
				if (tick_reg == TW'(TICK_CYC - 1)) begin
					tick_next = '0;
					if (dwell_reg <= `SSC_TW'(1)) begin
						state_next = S_SEEK;
					end else begin
						dwell_next = dwell_reg - `SSC_TW'(1);
					end
				end else begin
					tick_next = tick_reg + TW'(1);
				end
			end
			default: begin
			end
		endcase
		if (take) begin
			case (cmd_i.code)
				SSC_CMD_WRITE: begin
					if (in_range(cmd_i.addr_a)) begin
						// whole location replaced; function kept as no-function
						if (cmd_i.opt == SSC_OPT_CLEAR) begin
							mem_next[idx({1'b0, cmd_i.addr_a})] = '0;
						end else begin
							mem_next[idx({1'b0, cmd_i.addr_a})] =
								'{valid: 1'b1, volt: cmd_i.volt, curr: cmd_i.curr, dwell: cmd_i.dwell};
						end
					end
				end
				SSC_CMD_BOUNDS: begin
					if (!in_range(cmd_i.addr_a) || !in_range(cmd_i.addr_b) || cmd_i.addr_a > cmd_i.addr_b) begin
						execution_error_flag = 1'b1;
					end else begin
						start_next = cmd_i.addr_a;
						stop_next = cmd_i.addr_b;
					end
				end
				SSC_CMD_RUN: begin
					if (seq_init_i && state_reg == S_IDLE) begin
						ptr_next = {1'b0, start_reg};
						rep_next = repetition_i;
						endless_next = (repetition_i == 8'h00);
						found_next = 1'b0;
						step_mode_next = 1'b0;
						state_next = S_SEEK;
					end
				end
				SSC_CMD_PAUSE: begin
					if (state_reg == S_DWELL) begin
						state_next = S_HOLD;
					end
				end
				SSC_CMD_RESUME: begin
					if (state_reg == S_HOLD) begin
						state_next = S_SEEK;
					end
				end
				SSC_CMD_STEP_BEGIN: begin
					if (state_reg == S_IDLE) begin
						ptr_next = {1'b0, start_reg};
						found_next = 1'b0;
						step_mode_next = 1'b1;
						on_next = 1'b1;
						state_next = S_SEEK;
					end
				end
				SSC_CMD_STEP: begin
					if (state_reg == S_STEPW) begin
						state_next = S_SEEK;
					end
				end
				default: begin
				end
			endcase
		end
		// stop, explicit or by device reset; bounds are left alone
		if ((take && cmd_i.code == SSC_CMD_STOP) || dev_reset_i) begin
			if (stop_loc.valid) begin
				volt_next = stop_loc.volt;
				curr_next = stop_loc.curr;
			end else begin
				on_next = 1'b0;
			end
			cur_next = stop_reg;
			rep_next = 8'h00;
			endless_next = 1'b0;
			state_next = S_IDLE;
		end
		// a new error wins over a clear in the same cycle
		esr_next = esr_clear_i ? 8'h00 : esr_reg;
		esr_next[`SSC_EXE_BIT] = esr_next[`SSC_EXE_BIT] | execution_error_flag;
	end

	// --------------------------------------------------------------
	// location memory, one flip-flop group per location
	// --------------------------------------------------------------
	for (genvar g = 0; g < `SSC_NLOC; g++) begin : g_loc
		always_ff @(posedge clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				mem_reg[g] <= '0;
			end else begin
				mem_reg[g] <= mem_next[g];
			end
		end
	end

	// --------------------------------------------------------------
	// control registers
	// --------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= S_IDLE;
			step_mode_reg <= 1'b0;
			found_reg <= 1'b0;
			ptr_reg <= 9'h000;
			rep_reg <= 8'h00;
			endless_reg <= 1'b0;
			start_reg <= `SSC_START_RST;
			stop_reg <= `SSC_STOP_RST;
			cur_reg <= `SSC_START_RST;
			dwell_reg <= '0;
			tick_reg <= '0;
			volt_reg <= '0;
			curr_reg <= '0;
			on_reg <= 1'b0;
			esr_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			step_mode_reg <= step_mode_next;
			found_reg <= found_next;
			ptr_reg <= ptr_next;
			rep_reg <= rep_next;
			endless_reg <= endless_next;
			start_reg <= start_next;
			stop_reg <= stop_next;
			cur_reg <= cur_next;
			dwell_reg <= dwell_next;
			tick_reg <= tick_next;
			volt_reg <= volt_next;
			curr_reg <= curr_next;
			on_reg <= on_next;
			esr_reg <= esr_next;
		end
	end

	// --------------------------------------------------------------
	// replies and outputs
	// --------------------------------------------------------------
	assign volt_set_o = volt_reg;
	assign curr_set_o = curr_reg;
	assign output_on_o = on_reg;
	assign std_event_o = esr_reg;
	// step mode reports as running; hold only after a pause
	assign status_o.length = `SSC_STAT_LEN;
	assign status_o.state = (state_reg == S_IDLE) ? SSC_ST_READY :
		(state_reg == S_HOLD) ? SSC_ST_HOLD : SSC_ST_RUN;
	assign status_o.repeats = (state_reg == S_IDLE) ? 10'h000 :
		endless_reg ? `SSC_REP_ENDLESS : {2'b00, rep_reg};
	assign status_o.addr = cur_reg;
	assign bounds_o.length = `SSC_BOUNDS_LEN;
	assign bounds_o.start = start_reg;
	assign bounds_o.stop = stop_reg;
endmodule

// ---- ssc_seq_checker.sv ----
// port assertions for the setpoint sequence controller
// assumes one clock domain; bound onto every ssc_seq instance
`timescale 1ns/1ps
module ssc_seq_checker import ssc_pkg::*; (
	input wire logic clk_i, // system clock
	input wire logic nrst_i, // reset, active low
	input wire logic cmd_valid_i, // command offered
	input wire logic cmd_ready_o, // command accepted
	input wire ssc_cmd_t cmd_i, // command word
	input wire logic dev_reset_i, // device reset pulse
	input wire logic seq_init_i, // sequence initialized
	input wire logic esr_clear_i, // event register clear
	input wire ssc_status_t status_o, // status reply
	input wire ssc_bounds_t bounds_o, // bounds reply
	input wire logic [7:0] std_event_o // event register
);
	// ----
	// properties
	// ----
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// a command of the given code taken at this edge
	sequence took(ssc_cmd_code_t c);
		cmd_valid_i && cmd_ready_o && cmd_i.code == c;
	endsequence
	sequence bad_pair;
		took(SSC_CMD_BOUNDS) ##0 (cmd_i.addr_a > cmd_i.addr_b);
	endsequence
	stat_len_a: assert property (status_o.length == 8'h15) else $error("status length wrong");
	bnd_len_a: assert property (bounds_o.length == 8'h12) else $error("bounds length wrong");
	bnd_order_a: assert property (bounds_o.start >= 8'h0b && bounds_o.start <= bounds_o.stop)
		else $error("bounds out of order");
	bad_bounds_a: assert property (bad_pair |=> std_event_o[4] && $stable(bounds_o))
		else $error("reversed bounds not rejected");
	run_gate_a: assert property (took(SSC_CMD_RUN) ##0 (!seq_init_i && status_o.state == SSC_ST_READY)
		|=> status_o.state == SSC_ST_READY) else $error("run began uninitialized");
	stop_idle_a: assert property (took(SSC_CMD_STOP) |=> status_o.state == SSC_ST_READY && status_o.repeats == 10'h000)
		else $error("stop left sequence active");
	idle_rep_a: assert property (status_o.state == SSC_ST_READY |-> status_o.repeats == 10'h000)
		else $error("idle repeat count not zero");
	dev_stop_a: assert property (dev_reset_i && !cmd_valid_i |=> status_o.state == SSC_ST_READY && $stable(bounds_o))
		else $error("device reset mishandled");
	exe_hold_a: assert property (std_event_o[4] && !esr_clear_i |=> std_event_o[4])
		else $error("error flag lost");
	scan_bound_a: assert property (!cmd_ready_o |-> ##[1:600] cmd_ready_o)
		else $error("memory scan too long");
endmodule
bind ssc_seq ssc_seq_checker u_ssc_seq_checker (.clk_i, .nrst_i, .cmd_valid_i, .cmd_ready_o, .cmd_i,
	.dev_reset_i, .seq_init_i, .esr_clear_i, .status_o, .bounds_o, .std_event_o);

// ---- ssc_host.sv ----
// remote host model driving the command port
// assumes the bench calls send from one thread only
`timescale 1ns/1ps
module ssc_host import ssc_pkg::*; (
	input wire logic clk_i, // system clock
	input wire logic cmd_ready_i, // device accepts
	output logic cmd_valid_o, // command offered
	output ssc_cmd_t cmd_o // command word
);
	// ----
	// command issue
	// ----
	initial begin
		cmd_valid_o = 1'b0;
		cmd_o = '0;
	end
	// held until taken or for 900 cycles at most; the released word is inverted so stale data never looks valid
	task automatic send(input ssc_cmd_code_t c, input ssc_opt_t o, input logic [7:0] a, b,
		input logic [15:0] v, input logic [13:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cmd_o <= '{code: c, opt: o, addr_a: a, addr_b: b, volt: v, curr: ~v, dwell: d};
		cmd_valid_o <= 1'b1;
		do begin
			@(negedge clk_i);
			n++;
		end while (!cmd_ready_i && n < 900);
		@(posedge clk_i);
		cmd_valid_o <= 1'b0;
		cmd_o <= ssc_cmd_t'(~cmd_o);
		@(negedge clk_i);
	endtask
endmodule

// ---- ssc_seq_test.sv ----
// self-checking bench for the setpoint sequence controller
// assumes ssc_host drives commands; dwell unit shortened to 4 cycles
`timescale 1ns/1ps
module ssc_seq_test import ssc_pkg::*;;
	logic clk, nrst_n, dev_reset, seq_init, esr_clear, cmd_valid, cmd_ready, out_on;
	logic [7:0] reps, std_event;
	logic [13:0] def_dwell;
	logic [15:0] volt, curr;
	ssc_cmd_t cmd;
	ssc_status_t status;
	ssc_bounds_t bounds;
	int err_total = 0;
	int tests_run = 0;
	// ----
	// design and host
	// ----
	ssc_seq #(.TICK_CYC(4)) u_ssc_seq (.clk_i(clk), .nrst_i(nrst_n), .cmd_valid_i(cmd_valid),
		.cmd_ready_o(cmd_ready), .cmd_i(cmd), .dev_reset_i(dev_reset), .seq_init_i(seq_init),
		.repetition_i(reps), .default_dwell_i(def_dwell), .esr_clear_i(esr_clear), .volt_set_o(volt),
		.curr_set_o(curr), .output_on_o(out_on), .status_o(status), .bounds_o(bounds), .std_event_o(std_event));
	ssc_host u_ssc_host (.clk_i(clk), .cmd_ready_i(cmd_ready), .cmd_valid_o(cmd_valid), .cmd_o(cmd));
	// ----
	// helpers
	// ----
	task automatic chk(input string what, input logic [15:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_st(input ssc_report_t exp);
		tests_run++;
		if (status.state !== exp) begin
			err_total++;
			$display("unexpected state: expected %h seen %h", exp, status.state);
		end
	endtask
	// waits for the applied voltage to move, then compares it
	task automatic wait_v(input logic [15:0] exp);
		logic [15:0] old;
		int n;
		old = volt;
		n = 0;
		while (volt === old && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk("volt", exp, volt);
	endtask
	task automatic go(input ssc_cmd_code_t c, input logic [7:0] a = 8'h00, b = 8'h00);
		u_ssc_host.send(c, SSC_OPT_NONE, a, b, 16'h0000, 14'h0000);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [13:0] d, input ssc_opt_t o);
		u_ssc_host.send(SSC_CMD_WRITE, o, a, 8'h00, v, d);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_bounds;
		go(SSC_CMD_BOUNDS, 8'h14, 8'h16);
		chk("start", 16'h0014, 16'(bounds.start));
		chk("stop", 16'h0016, 16'(bounds.stop));
		go(SSC_CMD_BOUNDS, 8'h28, 8'h1e);
		chk("exe", 16'h0001, 16'(std_event[4]));
		chk("start", 16'h0014, 16'(bounds.start));
		@(posedge clk);
		esr_clear <= 1'b1;
		@(posedge clk);
		esr_clear <= 1'b0;
		@(negedge clk);
		chk("exe", 16'h0000, 16'(std_event[4]));
		$display("bounds test done");
	endtask
	task automatic t_run;
		wr(8'h14, 16'h0001, 14'h0003, SSC_OPT_ON);
		wr(8'h15, 16'h0009, 14'h0001, SSC_OPT_NONE);
		wr(8'h15, 16'h0009, 14'h0001, SSC_OPT_CLEAR);
		wr(8'h16, 16'h0002, 14'h0000, SSC_OPT_OFF);
		go(SSC_CMD_RUN);
		chk_st(SSC_ST_READY);
		@(posedge clk);
		seq_init <= 1'b1;
		reps <= 8'h02;
		go(SSC_CMD_RUN);
		wait_v(16'h0001);
		chk("curr", 16'hfffe, curr);
		chk("rep", 16'h0002, 16'(status.repeats));
		repeat (11) @(negedge clk);
		chk("dwell", 16'h0001, volt);
		wait_v(16'h0002);
		repeat (19) @(negedge clk);
		chk("dflt", 16'h0002, volt);
		wait_v(16'h0001);
		chk("rep", 16'h0001, 16'(status.repeats));
		repeat (120) @(negedge clk);
		chk_st(SSC_ST_READY);
		$display("run test done");
	endtask
	task automatic t_pause;
		@(posedge clk);
		reps <= 8'h00;
		go(SSC_CMD_RUN);
		wait_v(16'h0001);
		wait_v(16'h0002);
		chk("rep", 16'h03e7, 16'(status.repeats));
		go(SSC_CMD_PAUSE);
		chk_st(SSC_ST_HOLD);
		chk("addr", 16'h0016, 16'(status.addr));
		repeat (40) @(negedge clk);
		chk("hold", 16'h0002, volt);
		go(SSC_CMD_RESUME);
		wait_v(16'h0001);
		go(SSC_CMD_STOP);
		chk("stopv", 16'h0002, volt);
		$display("pause test done");
	endtask
	task automatic t_step;
		go(SSC_CMD_STEP_BEGIN);
		wait_v(16'h0001);
		chk("on", 16'h0001, 16'(out_on));
		go(SSC_CMD_STEP);
		wait_v(16'h0002);
		repeat (30) @(negedge clk);
		chk("wait", 16'h0002, volt);
		go(SSC_CMD_STOP);
		chk_st(SSC_ST_READY);
		chk("stopv", 16'h0002, volt);
		go(SSC_CMD_BOUNDS, 8'h14, 8'h17);
		go(SSC_CMD_STEP_BEGIN);
		wait_v(16'h0001);
		go(SSC_CMD_STOP);
		chk("off", 16'h0000, 16'(out_on));
		chk("last", 16'h0001, volt);
		go(SSC_CMD_STEP_BEGIN);
		repeat (4) @(posedge clk);
		dev_reset <= 1'b1;
		@(posedge clk);
		dev_reset <= 1'b0;
		@(negedge clk);
		chk_st(SSC_ST_READY);
		chk("off", 16'h0000, 16'(out_on));
		chk("stop", 16'h0017, 16'(bounds.stop));
		$display("step test done");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----
	// clock, sequence, watchdog
	// ----
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		nrst_n = 1'b0;
		dev_reset = 1'b0;
		seq_init = 1'b0;
		esr_clear = 1'b0;
		reps = 8'h00;
		def_dwell = 14'h0005;
		repeat (12) @(posedge clk);
		nrst_n <= 1'b1;
		t_bounds;
		t_run;
		t_pause;
		t_step;
		report_and_stop;
	end
	// generous span: the scenarios need a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		report_and_stop;
	end
endmodule
